// >>> core/gcr_reg_bank.sv
// Register bank of a three-axis rate sensor, byte access from the serial port engine.
// Assumes addrStb, wrStb and rdStb are one-cycle pulses framed by the bus transfer.
`timescale 1ns/1ns
// Summary of operation
// - Single and burst access; pointer advances per byte, parks in reserved area.
// - Bus address held in identity bits 6:1, writable; host keeps bit 7 zero.
// - Filter code 0 samples at 8 kHz, 1 to 6 at 1 kHz, 7 reserved.
// - New result loaded every divider plus one internal sampling periods.
// - Divider is a full 8-bit register, any value, reset zero.
// - Range field bits 4:3 resets to zero; code 3 is the valid range.
// - Polarity bit 7 set makes the interrupt pin active low.
// - Drive bit 6 set makes the pin open drain, driving low only.
// - Latch bit 5 holds the pin until cleared, else 50 us pulse.
// - Clear bit 4 set clears on any read, else on status read only.
// - Clock-ready enable raises interrupt when the PLL locks after a change to a source other than the oscillator.
// - Data-ready enable raises interrupt per new sample; setup register resets zero.
// - A status flag sets only when its source fires and is enabled.
// - Flags behave independently of pin polarity and pulse or latch choice.
// - Temperature and rate results are 16-bit two's complement, high and low bytes.
module gcr_reg_bank import gcr_pkg::*; #(
    parameter int INT_8K_CYC = CYC_8K,
    parameter int INT_1K_CYC = CYC_1K,
    parameter int PULSE_CYC = CYC_PULSE,
    parameter logic [5:0] BUS_ADDR_RST = 6'h2a // Arbitrary value
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Register access from the serial engine
    input wire logic addrStb,
    input wire logic [7:0] addrIn,
    input wire logic wrStb,
    input wire logic [7:0] wrData,
    input wire logic rdStb,
    output logic [7:0] rdData,
    // Sensor path
    input wire gcr_sample_s sampleIn,
    input wire logic pllLocked,
    output logic sampleTick,
    // Configuration to the rest of the device
    output logic [5:0] busAddress,
    output logic [2:0] filterSetting,
    output logic [1:0] rangeSelect,
    output logic [7:0] powerControl,
    // Interrupt pin
    output logic intOut,
    output logic intOe
);
    // Pointer step: parks once it reaches the reserved area
    function automatic logic [7:0] nextPtr(input logic [7:0] p);
        if (p >= ADDR_HOLD_LO && p <= ADDR_HOLD_HI) begin
            nextPtr = p;
        end else begin
            nextPtr = p + 8'h01;
        end
    endfunction : nextPtr

    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [5:0] ident_q;
    logic [7:0] div_q;
    logic [7:0] filt_q;
    logic [7:0] icfg_q;
    logic [7:0] pwr_q;
    logic clkFlag_q;
    logic clkFlag_d;
    logic drdyFlag_q;
    logic drdyFlag_d;
    logic clkPending_q;
    logic pllLocked_q;
    logic [7:0] rdData_q;
    logic [7:0] readByte;
    gcr_sample_s data_q;
    gcr_irqpin_s pinCfg;
    logic newSample;

    // Access decode
    wire access = wrStb || rdStb;
    wire wrIdent = wrStb && ptr_q == ADDR_IDENTITY;
    wire wrDiv = wrStb && ptr_q == ADDR_DIVIDER;
    wire wrFilt = wrStb && ptr_q == ADDR_FILTER;
    wire wrIcfg = wrStb && ptr_q == ADDR_IRQ_SETUP;
    wire wrPwr = wrStb && ptr_q == ADDR_POWER;
    wire inHold = ptr_q >= ADDR_HOLD_LO && ptr_q <= ADDR_HOLD_HI;

    assign ptr_d = addrStb ? addrIn : (access ? nextPtr(ptr_q) : ptr_q);

    // Interrupt sources
    wire [2:0] newClkSel = wrData[CLKSEL_MSB:0];
    wire clkChange = wrPwr && newClkSel != pwr_q[CLKSEL_MSB:0] && newClkSel != CLKSEL_OSC;
    wire lockEvent = clkPending_q && pllLocked && !pllLocked_q;
    wire clkSet = lockEvent && icfg_q[IRQ_CLKRDY_BIT];
    wire drdySet = newSample && icfg_q[IRQ_DRDY_BIT];
    wire rdClear = rdStb && (icfg_q[IRQ_ANYRD_BIT] || ptr_q == ADDR_FLAGS);

    // Set wins over a read clear in the same cycle
    assign clkFlag_d = clkSet || (clkFlag_q && !rdClear);
    assign drdyFlag_d = drdySet || (drdyFlag_q && !rdClear);

    // Pin setup; flags above do not look at it
    assign pinCfg.polarityLow = icfg_q[IRQ_POL_BIT];
    assign pinCfg.openDrain = icfg_q[IRQ_OD_BIT];
    assign pinCfg.latchMode = icfg_q[IRQ_LATCH_BIT];

    always_comb begin
        case (ptr_q)
            ADDR_IDENTITY: readByte = {1'b0, ident_q, 1'b0};
            ADDR_DIVIDER: readByte = div_q;
            ADDR_FILTER: readByte = filt_q;
            ADDR_IRQ_SETUP: readByte = icfg_q;
            ADDR_FLAGS: readByte = {5'h00, clkFlag_q, 1'b0, drdyFlag_q};
            ADDR_TEMP_HI: readByte = data_q.temp[15:8];
            ADDR_TEMP_LO: readByte = data_q.temp[7:0];
            ADDR_RATEX_HI: readByte = data_q.rateX[15:8];
            ADDR_RATEX_LO: readByte = data_q.rateX[7:0];
            ADDR_RATEY_HI: readByte = data_q.rateY[15:8];
            ADDR_RATEY_LO: readByte = data_q.rateY[7:0];
            ADDR_RATEZ_HI: readByte = data_q.rateZ[15:8];
            ADDR_RATEZ_LO: readByte = data_q.rateZ[7:0];
            ADDR_POWER: readByte = pwr_q;
            default: readByte = RST_ZERO;
        endcase
    end

    // Pointer and read data
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= RST_ZERO;
            rdData_q <= RST_ZERO;
        end else begin
            ptr_q <= ptr_d;
            if (rdStb) begin
                rdData_q <= readByte;
            end
        end
    end

    // Writable registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ident_q <= BUS_ADDR_RST;
            div_q <= RST_ZERO;
            filt_q <= RST_ZERO;
            icfg_q <= RST_ZERO;
            pwr_q <= RST_ZERO;
        end else begin
            if (wrIdent) begin
                ident_q <= wrData[ID_MSB:ID_LSB];
            end
            if (wrDiv) begin
                div_q <= wrData;
            end
            if (wrFilt) begin
                filt_q <= wrData & FILTER_MASK;
            end
            if (wrIcfg) begin
                icfg_q <= wrData & IRQ_SETUP_MASK;
            end
            if (wrPwr) begin
                pwr_q <= wrData;
            end
        end
    end

    // Status flags, lock tracking and result registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clkFlag_q <= 1'b0;
            drdyFlag_q <= 1'b0;
            clkPending_q <= 1'b0;
            pllLocked_q <= 1'b0;
            data_q <= '0;
        end else begin
            clkFlag_q <= clkFlag_d;
            drdyFlag_q <= drdyFlag_d;
            pllLocked_q <= pllLocked;
            clkPending_q <= clkChange || (clkPending_q && !lockEvent);
            if (newSample) begin
                data_q <= sampleIn;
            end
        end
    end

    gcr_sample_timer #(
        .FAST_CYC(INT_8K_CYC),
        .SLOW_CYC(INT_1K_CYC)
    ) u_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .filterSetting(filt_q[FILT_MSB:0]),
        .divider(div_q),
        .internalTick(),
        .sampleTick(newSample)
    );

    gcr_irq_pin #(
        .PULSE_CYC(PULSE_CYC)
    ) u_pin (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .cfg(pinCfg),
        .irqEvent(clkSet || drdySet),
        .irqLatched(clkFlag_q || drdyFlag_q),
        .intOut(intOut),
        .intOe(intOe)
    );

    assign rdData = rdData_q;
    assign sampleTick = newSample;
    assign busAddress = ident_q;
    assign filterSetting = filt_q[FILT_MSB:0];
    assign rangeSelect = filt_q[RANGE_MSB:RANGE_LSB];
    assign powerControl = pwr_q;

    a_burst_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        access && !addrStb && !inHold |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer did not advance after a byte");

    a_burst_park: assert property (@(posedge ref_clk) disable iff (!rstn)
        access && !addrStb && inHold |=> $stable(ptr_q))
        else $error("pointer left the reserved area");

    a_addr_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrIdent && !addrStb |=> busAddress == $past(wrData[ID_MSB:ID_LSB]))
        else $error("bus address not taken from write");

    a_div_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrDiv |=> div_q == $past(wrData))
        else $error("divider not written whole");

    a_status_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        !drdyFlag_q ##1 drdyFlag_q |-> $past(newSample) && $past(icfg_q[IRQ_DRDY_BIT]))
        else $error("data flag set without enabled source");

    a_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
        (drdySet |=> drdyFlag_q) and (clkSet |=> clkFlag_q))
        else $error("flag set lost against read clear");

    a_read_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdClear && !drdySet && !clkSet |=> !drdyFlag_q && !clkFlag_q)
        else $error("read did not clear status");

    a_data_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        newSample |=> data_q == $past(sampleIn))
        else $error("sample not loaded on tick");

    a_read_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdStb && ptr_q == ADDR_RATEX_HI |=> rdData == $past(data_q.rateX[15:8]))
        else $error("high byte read wrong");

    a_low_byte: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdStb && ptr_q == ADDR_RATEZ_LO |=> rdData == $past(data_q.rateZ[7:0]))
        else $error("low byte read wrong");

    a_ident_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdStb && ptr_q == ADDR_IDENTITY |=> rdData == {1'b0, $past(ident_q), 1'b0})
        else $error("identity read does not show the bus address");

    a_addr_load: assert property (@(posedge ref_clk) disable iff (!rstn)
        addrStb |=> ptr_q == $past(addrIn))
        else $error("pointer not loaded from the address byte");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdStb && inHold |=> rdData == RST_ZERO)
        else $error("reserved area read not zero");

    a_filt_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrFilt |=> filt_q == ($past(wrData) & FILTER_MASK))
        else $error("filter register keeps undefined bits");

    a_setup_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrIcfg |=> icfg_q == ($past(wrData) & IRQ_SETUP_MASK))
        else $error("setup register keeps undefined bits");

    a_range_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrFilt |=> rangeSelect == $past(wrData[RANGE_MSB:RANGE_LSB]))
        else $error("range field not taken from write");

    a_pend_arm: assert property (@(posedge ref_clk) disable iff (!rstn)
        wrPwr && wrData[CLKSEL_MSB:0] != CLKSEL_OSC
            && wrData[CLKSEL_MSB:0] != powerControl[CLKSEL_MSB:0] |=> clkPending_q)
        else $error("clock source change not armed");

    a_clk_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        !clkFlag_q ##1 clkFlag_q |-> $past(lockEvent) && $past(icfg_q[IRQ_CLKRDY_BIT]))
        else $error("clock flag set without enabled lock event");

    a_flags_read: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdStb && ptr_q == ADDR_FLAGS |=> rdData[FLAG_DRDY_BIT] == $past(drdyFlag_q)
            && rdData[FLAG_CLKRDY_BIT] == $past(clkFlag_q))
        else $error("status read does not show the flags");

    a_drdy_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !drdySet && !rdClear |=> drdyFlag_q == $past(drdyFlag_q))
        else $error("data flag moved without set or clear");

    a_clk_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        !clkSet && !rdClear |=> clkFlag_q == $past(clkFlag_q))
        else $error("clock flag moved without set or clear");

    a_keep_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
        rdStb && !icfg_q[IRQ_ANYRD_BIT] && ptr_q != ADDR_FLAGS && drdyFlag_q |=> drdyFlag_q)
        else $error("other read cleared the status");

endmodule : gcr_reg_bank

// >>> include/gcr_pkg.sv
// Package of the rate sensor register bank: offsets, fields, timing and carriers.
// Assumes a 100 MHz ref_clk and byte-level register access from the serial port engine.
package gcr_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INT_PERIOD_8K_NS = 125000;
    localparam int INT_PERIOD_1K_NS = 1000000;
    localparam int IRQ_PULSE_US = 50;
    localparam int CYC_8K = INT_PERIOD_8K_NS / CLK_PERIOD_NS;
    localparam int CYC_1K = INT_PERIOD_1K_NS / CLK_PERIOD_NS;
    localparam int CYC_PULSE = (IRQ_PULSE_US * 1000) / CLK_PERIOD_NS;
    localparam int TMR_W = 17;
    localparam int PULSE_W = 16;

    // Register offsets
    localparam logic [7:0] ADDR_IDENTITY = 8'h00;
    localparam logic [7:0] ADDR_DIVIDER = 8'h15;
    localparam logic [7:0] ADDR_FILTER = 8'h16;
    localparam logic [7:0] ADDR_IRQ_SETUP = 8'h17;
    localparam logic [7:0] ADDR_FLAGS = 8'h1a;
    localparam logic [7:0] ADDR_TEMP_HI = 8'h1b;
    localparam logic [7:0] ADDR_TEMP_LO = 8'h1c;
    localparam logic [7:0] ADDR_RATEX_HI = 8'h1d;
    localparam logic [7:0] ADDR_RATEX_LO = 8'h1e;
    localparam logic [7:0] ADDR_RATEY_HI = 8'h1f;
    localparam logic [7:0] ADDR_RATEY_LO = 8'h20;
    localparam logic [7:0] ADDR_RATEZ_HI = 8'h21;
    localparam logic [7:0] ADDR_RATEZ_LO = 8'h22;
    localparam logic [7:0] ADDR_POWER = 8'h3e;
    // Burst pointer parks on the first reserved address it reaches
    localparam logic [7:0] ADDR_HOLD_LO = 8'h23;
    localparam logic [7:0] ADDR_HOLD_HI = 8'h3d;

    // Fields and reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] FILTER_MASK = 8'h1f;
    localparam logic [7:0] IRQ_SETUP_MASK = 8'hf5;
    localparam logic [2:0] FILT_8K = 3'h0;
    localparam logic [2:0] FILT_RSVD = 3'h7;
    localparam logic [2:0] CLKSEL_OSC = 3'h0;
    localparam int ID_LSB = 1;
    localparam int ID_MSB = 6;
    localparam int RANGE_LSB = 3;
    localparam int RANGE_MSB = 4;
    localparam int FILT_MSB = 2;
    localparam int CLKSEL_MSB = 2;
    localparam int IRQ_POL_BIT = 7;
    localparam int IRQ_OD_BIT = 6;
    localparam int IRQ_LATCH_BIT = 5;
    localparam int IRQ_ANYRD_BIT = 4;
    localparam int IRQ_CLKRDY_BIT = 2;
    localparam int IRQ_DRDY_BIT = 0;
    localparam int FLAG_CLKRDY_BIT = 2;
    localparam int FLAG_DRDY_BIT = 0;

    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] rateX;
        logic [15:0] rateY;
        logic [15:0] rateZ;
    } gcr_sample_s;

    typedef struct packed {
        logic polarityLow;
        logic openDrain;
        logic latchMode;
    } gcr_irqpin_s;

    typedef enum logic {
        PIN_IDLE = 1'b0,
        PIN_PULSE = 1'b1
    } gcr_pin_e;

endpackage : gcr_pkg

// >>> core/gcr_sample_timer.sv
// Internal sampling tick (8 kHz or 1 kHz) and output-rate divider.
// Assumes ref_clk at 100 MHz; ticks are one-cycle pulses.
`timescale 1ns/1ns
module gcr_sample_timer import gcr_pkg::*; #(
    parameter int FAST_CYC = CYC_8K,
    parameter int SLOW_CYC = CYC_1K
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Configuration
    input wire logic [2:0] filterSetting,
    input wire logic [7:0] divider,
    // Ticks
    output logic internalTick,
    output logic sampleTick
);
    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    logic [7:0] divCnt_q;
    logic [7:0] divCnt_d;
    logic tick_q;
    logic sample_q;

    wire fast = (filterSetting == FILT_8K);
    wire halted = (filterSetting == FILT_RSVD);
    wire [TMR_W-1:0] limit = fast ? TMR_W'(FAST_CYC - 1) : TMR_W'(SLOW_CYC - 1);
    wire periodEnd = !halted && (cnt_q >= limit);
    wire divEnd = (divCnt_q >= divider);

    assign cnt_d = (halted || periodEnd) ? '0 : cnt_q + TMR_W'(1);
    assign divCnt_d = periodEnd ? (divEnd ? 8'h00 : divCnt_q + 8'h01) : divCnt_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            divCnt_q <= 8'h00;
            tick_q <= 1'b0;
            sample_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            divCnt_q <= divCnt_d;
            tick_q <= periodEnd;
            sample_q <= periodEnd && divEnd;
        end
    end

    assign internalTick = tick_q;
    assign sampleTick = sample_q;

    a_rate_period: assert property (@(posedge ref_clk) disable iff (!rstn)
        periodEnd |=> internalTick && cnt_q == '0 && $past(cnt_q) >= $past(limit))
        else $error("internal tick not at end of selected period");

    a_divided_rate: assert property (@(posedge ref_clk) disable iff (!rstn)
        sampleTick |-> $past(divCnt_q) >= $past(divider) && $past(periodEnd))
        else $error("sample tick without divider expiry");

endmodule : gcr_sample_timer

// >>> core/gcr_irq_pin.sv
// Interrupt pin driver: polarity, push-pull or open drain, latch or timed pulse.
// Assumes one-cycle event pulses and a latched level from the register bank.
`timescale 1ns/1ns
module gcr_irq_pin import gcr_pkg::*; #(
    parameter int PULSE_CYC = CYC_PULSE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Pin setup
    input wire gcr_irqpin_s cfg,
    // Interrupt sources
    input wire logic irqEvent,
    input wire logic irqLatched,
    // Pin
    output logic intOut,
    output logic intOe
);
    gcr_pin_e state_q;
    logic [PULSE_W-1:0] cnt_q;
    logic out_q;
    logic oe_q;

    wire startPulse = irqEvent && !cfg.latchMode;
    wire lastCycle = (cnt_q == '0);
    wire active = cfg.latchMode ? irqLatched : (state_q == PIN_PULSE);
    wire level = active ^ cfg.polarityLow;
    wire pinOut = cfg.openDrain ? 1'b0 : level;
    wire pinOe = cfg.openDrain ? !level : 1'b1;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= PIN_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                PIN_IDLE: begin
                    if (startPulse) begin
                        state_q <= PIN_PULSE;
                        cnt_q <= PULSE_W'(PULSE_CYC - 1);
                    end
                end
                PIN_PULSE: begin
                    if (cfg.latchMode || lastCycle) begin
                        state_q <= PIN_IDLE;
                    end else begin
                        cnt_q <= cnt_q - PULSE_W'(1);
                    end
                end
                default: state_q <= PIN_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            out_q <= pinOut;
            oe_q <= pinOe;
        end
    end

    assign intOut = out_q;
    assign intOe = oe_q;

    a_pulse_start: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == PIN_IDLE && startPulse |=> state_q == PIN_PULSE
            && cnt_q == PULSE_W'(PULSE_CYC - 1))
        else $error("pulse not started with full length");

    a_open_drain: assert property (@(posedge ref_clk) disable iff (!rstn)
        cfg.openDrain |=> !intOut && intOe == !$past(level))
        else $error("open drain pin drives high");

    a_pin_polarity: assert property (@(posedge ref_clk) disable iff (!rstn)
        !cfg.openDrain |=> intOe && intOut == ($past(active) ^ $past(cfg.polarityLow)))
        else $error("push-pull level does not follow polarity");

endmodule : gcr_irq_pin

// >>> tb/gcr_host_model.sv
// Host side model: byte-level register accesses and the resolved interrupt wire.
// Assumes strobes are sampled on the rising edge of ref_clk and change on the falling edge.
`timescale 1ns/1ns
module gcr_host_model (
    // Clock
    input wire logic ref_clk,
    // Register access
    output logic addrStb,
    output logic [7:0] addrIn,
    output logic wrStb,
    output logic [7:0] wrData,
    output logic rdStb,
    input wire logic [7:0] rdData,
    // Interrupt wire
    input wire logic intOut,
    input wire logic intOe,
    output logic intPin
);
    // Pull-up holds the wire high whenever the device releases it
    assign intPin = intOe ? intOut : 1'b1;

    initial begin
        addrStb = 1'b0;
        addrIn = 8'h00;
        wrStb = 1'b0;
        wrData = 8'h00;
        rdStb = 1'b0;
    end

    // Released data lines show the inverse so a stale value is never mistaken for a new one
    task automatic set_addr(input logic [7:0] a);
        @(negedge ref_clk);
        addrStb = 1'b1;
        addrIn = a;
        @(negedge ref_clk);
        addrStb = 1'b0;
        addrIn = ~a;
    endtask : set_addr

    task automatic wr_byte(input logic [7:0] d);
        @(negedge ref_clk);
        wrStb = 1'b1;
        wrData = d;
        @(negedge ref_clk);
        wrStb = 1'b0;
        wrData = ~d;
    endtask : wr_byte

    task automatic rd_byte(output logic [7:0] d);
        @(negedge ref_clk);
        rdStb = 1'b1;
        @(negedge ref_clk);
        rdStb = 1'b0;
        d = rdData;
    endtask : rd_byte
endmodule : gcr_host_model

// >>> tb/gcr_reg_bank_test.sv
// Self-checking bench of the rate sensor register bank.
// Assumes shortened sampling and pulse counts set through the bank's parameters.
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module gcr_reg_bank_test import gcr_pkg::*;;
    localparam int FAST = 20;
    localparam int SLOW = 40;
    localparam int PULSE = 10;
    localparam logic [5:0] ID_RST = 6'h2a; // Arbitrary value
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic pllLocked = 1'b0;
    gcr_sample_s smp = {16'h8123, 16'h7f01, 16'hfe02, 16'h0403};
    logic addrStb, wrStb, rdStb, sampleTick, intOut, intOe, intPin;
    logic [7:0] addrIn, wrData, rdData, powerControl, rv;
    logic [5:0] busAddress;
    logic [2:0] filterSetting;
    logic [1:0] rangeSelect;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    always #5 ref_clk = ~ref_clk;

    gcr_reg_bank #(.INT_8K_CYC(FAST), .INT_1K_CYC(SLOW), .PULSE_CYC(PULSE),
        .BUS_ADDR_RST(ID_RST)) dut (.ref_clk(ref_clk), .rstn(rstn), .addrStb(addrStb),
        .addrIn(addrIn), .wrStb(wrStb), .wrData(wrData), .rdStb(rdStb), .rdData(rdData),
        .sampleIn(smp), .pllLocked(pllLocked), .sampleTick(sampleTick),
        .busAddress(busAddress), .filterSetting(filterSetting), .rangeSelect(rangeSelect),
        .powerControl(powerControl), .intOut(intOut), .intOe(intOe));

    gcr_host_model host (.ref_clk(ref_clk), .addrStb(addrStb), .addrIn(addrIn),
        .wrStb(wrStb), .wrData(wrData), .rdStb(rdStb), .rdData(rdData), .intOut(intOut),
        .intOe(intOe), .intPin(intPin));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        host.set_addr(a);
        host.wr_byte(d);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.set_addr(a);
        host.rd_byte(d);
        `CHK(d, e)
    endtask : rd_chk

    task automatic wait_tick();
        int k;
        k = 0;
        @(negedge ref_clk);
        while (sampleTick !== 1'b1 && k < 6000) begin
            @(negedge ref_clk);
            k++;
        end
        `CHK(sampleTick, 1'b1)
    endtask : wait_tick

    task automatic check_gap(input int e);
        int k;
        wait_tick();
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (sampleTick !== 1'b1 && k < 3000);
        `CHK(k, e)
    endtask : check_gap

    task automatic pin_chk(input logic e);
        repeat (4) @(negedge ref_clk);
        `CHK(intPin, e)
    endtask : pin_chk

    // Cuts a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        repeat (12) @(negedge ref_clk);
        rstn = 1'b1;
        rd_chk(ADDR_IDENTITY, {1'b0, ID_RST, 1'b0});
        rd_chk(ADDR_DIVIDER, 8'h00);
        rd_chk(ADDR_FILTER, 8'h00);
        rd_chk(ADDR_IRQ_SETUP, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h00);
        wr_reg(ADDR_IDENTITY, 8'h7e);
        rd_chk(ADDR_IDENTITY, 8'h7e);
        `CHK(busAddress, 6'h3f)
        wr_reg(ADDR_FLAGS, 8'h01);
        rd_chk(ADDR_FLAGS, 8'h00);
        // Burst write then burst read of divider, filter and setup
        host.set_addr(ADDR_DIVIDER);
        host.wr_byte(8'h03);
        host.wr_byte(8'h18);
        host.wr_byte(8'h00);
        host.set_addr(ADDR_DIVIDER);
        host.rd_byte(rv);
        `CHK(rv, 8'h03)
        host.rd_byte(rv);
        `CHK(rv, 8'h18)
        host.rd_byte(rv);
        `CHK(rv, 8'h00)
        `CHK(rangeSelect, 2'h3)
        check_gap(4 * FAST);
        wr_reg(ADDR_DIVIDER, 8'h00);
        wr_reg(ADDR_FILTER, 8'h19);
        check_gap(SLOW);
        wr_reg(ADDR_FILTER, 8'h1e);
        check_gap(SLOW);
        wr_reg(ADDR_FILTER, 8'h1f);
        n = 0;
        repeat (300) begin
            @(negedge ref_clk);
            n += int'(sampleTick === 1'b1);
        end
        `CHK(n, 0)
        `CHK(filterSetting, 3'h7)
        wr_reg(ADDR_FILTER, 8'h18);
        wait_tick();
        host.set_addr(ADDR_TEMP_HI);
        for (int i = 0; i < 8; i++) begin
            host.rd_byte(rv);
            `CHK(rv, smp[63 - 8 * i -: 8])
        end
        host.rd_byte(rv);
        `CHK(rv, 8'h00)
        // Latched, active high, cleared only by a status read
        wr_reg(ADDR_DIVIDER, 8'hff);
        rd_chk(ADDR_DIVIDER, 8'hff);
        wr_reg(ADDR_IRQ_SETUP, 8'h21);
        wait_tick();
        pin_chk(1'b1);
        rd_chk(ADDR_DIVIDER, 8'hff);
        pin_chk(1'b1);
        rd_chk(ADDR_FLAGS, 8'h01);
        pin_chk(1'b0);
        rd_chk(ADDR_FLAGS, 8'h00);
        // Latched, active low, open drain, cleared by any read
        wr_reg(ADDR_IRQ_SETUP, 8'hf1);
        pin_chk(1'b1);
        `CHK(intOe, 1'b0)
        wait_tick();
        pin_chk(1'b0);
        `CHK(intOe, 1'b1)
        rd_chk(ADDR_DIVIDER, 8'hff);
        pin_chk(1'b1);
        rd_chk(ADDR_FLAGS, 8'h00);
        // Pulse mode: fixed width, flag unaffected
        wr_reg(ADDR_IRQ_SETUP, 8'h01);
        wait_tick();
        n = 0;
        repeat (40) begin
            @(negedge ref_clk);
            n += int'(intPin === 1'b1);
        end
        `CHK(n >= PULSE && n <= PULSE + 1, 1'b1)
        rd_chk(ADDR_FLAGS, 8'h01);
        // Source disabled: no flag, no pin
        wr_reg(ADDR_IRQ_SETUP, 8'h00);
        wait_tick();
        pin_chk(1'b0);
        rd_chk(ADDR_FLAGS, 8'h00);
        // Clock ready after a change of clock source
        wr_reg(ADDR_IRQ_SETUP, 8'h24);
        wr_reg(ADDR_POWER, 8'h01);
        `CHK(powerControl, 8'h01)
        pin_chk(1'b0);
        pllLocked = 1'b1;
        pin_chk(1'b1);
        rd_chk(ADDR_FLAGS, 8'h04);
        pin_chk(1'b0);
        print_verdict();
    end
endmodule : gcr_reg_bank_test
